// file: verilog/tcc_pkg.sv
// constants, register map and carrier types for the timer capture/compare block
package tcc_pkg;

  localparam int NUM_CH  = 6;
  localparam int NUM_CAP = 4;
  localparam int CNT_W   = 16;
  localparam int ADR_W   = 8;
  localparam int STAT_W  = 12;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADR_W-1:0] OFS_GT_CNT    = 8'h04;
  localparam logic [ADR_W-1:0] OFS_GT_RELOAD = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CT_CNT    = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_CT_RELOAD = 8'h10;
  localparam logic [ADR_W-1:0] OFS_TB_SEL    = 8'h14;
  localparam logic [ADR_W-1:0] OFS_CH_MODE   = 8'h18;
  localparam logic [ADR_W-1:0] OFS_CAP_CFG   = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_M1_LEVEL  = 8'h20;
  localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h24;
  localparam logic [ADR_W-1:0] OFS_MASK      = 8'h28;
  localparam logic [ADR_W-1:0] OFS_OUT_STATE = 8'h2c;
  localparam logic [ADR_W-1:0] OFS_SHADOW0   = 8'h40;
  localparam logic [ADR_W-1:0] OFS_VALUE0    = 8'h60;

  // control register fields
  localparam int CTRL_GT_RUN   = 0;
  localparam int CTRL_CT_RUN   = 1;
  localparam int CTRL_CLK2X    = 2;
  localparam int CTRL_CASCADE  = 3;
  localparam int CTRL_CT_FORCE = 4;
  localparam int CTRL_SW_XFER  = 5;
  localparam int CTRL_AUTO_XF  = 6;
  localparam int CTRL_CONCUR   = 7;
  localparam int CTRL_LVL_A    = 8;
  localparam int CTRL_LVL_B    = 9;
  localparam logic [31:0] CTRL_STORED_MASK = 32'h0000_03cf;

  // capture config: per channel 3 bits, edge select [1:0], software mode [2]
  localparam int CAP_FLD_W   = 3;
  localparam int CAP_SW_BIT  = 2;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // status bit positions
  localparam int ST_MATCH0 = 0;
  localparam int ST_CAP0   = 6;
  localparam int ST_GT_OVF = 10;
  localparam int ST_CT_OVF = 11;

  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
  localparam int               GROUP_A_HI = 2;

  typedef enum logic [1:0] {MODE_OFF, MODE_CMP0, MODE_CMP1, MODE_CAPTURE} mode_type;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_type;

endpackage

// file: verilog/timer_capture_compare_block.sv
// timer capture/compare block: two 16-bit timers, six compare and four capture channels
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module timer_capture_compare_block
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire tcc_pkg::wb_req_type         wb_req,
  output tcc_pkg::wb_rsp_type              wb_rsp,
  input  wire logic [tcc_pkg::NUM_CAP-1:0] cap_in,
  output logic [tcc_pkg::NUM_CH-1:0]       cmp_out,
  output logic [tcc_pkg::NUM_CH-1:0]       cmp_oe,
  output logic                             irq
);
  import tcc_pkg::*;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [ADR_W-1:0] ch_ofs(input logic [ADR_W-1:0] base, input int ch);
    return base + ADR_W'(ch * 4);
  endfunction

  logic                 ack_reg;
  logic [31:0]          rdat_reg;
  logic [31:0]          rdat_next;
  logic [31:0]          ctrl_reg;
  logic [CNT_W-1:0]     gt_cnt_reg;
  logic [CNT_W-1:0]     gt_reload_reg;
  logic [CNT_W-1:0]     ct_cnt_reg;
  logic [CNT_W-1:0]     ct_reload_reg;
  logic [NUM_CH-1:0]    tb_sel_reg;
  mode_type             mode_reg   [NUM_CH];
  logic [NUM_CAP*CAP_FLD_W-1:0] cap_cfg_reg;
  logic [NUM_CH-1:0]    m1_level_reg;
  logic [STAT_W-1:0]    status_reg;
  logic [STAT_W-1:0]    mask_reg;
  logic [CNT_W-1:0]     shadow_reg [NUM_CH];
  logic [CNT_W-1:0]     value_reg  [NUM_CH];
  logic [NUM_CH-1:0]    out_reg;
  logic [NUM_CH-1:0]    oe_reg;
  logic [NUM_CAP-1:0]   cap_prev_reg;
  logic                 div_reg;
  logic                 irq_reg;

  logic                 bus_req;
  logic                 wr;
  logic                 tick;
  logic                 gt_step;
  logic                 gt_ovf;
  logic                 ct_inc;
  logic                 ct_step;
  logic                 ct_force;
  logic                 ct_ovf;
  logic                 sw_xfer;
  logic [CNT_W-1:0]     ch_cnt     [NUM_CH];
  logic [CNT_W-1:0]     ch_reload  [NUM_CH];
  logic [CNT_W-1:0]     cmp_after  [NUM_CH];
  logic [NUM_CH-1:0]    ch_ovf;
  logic [NUM_CH-1:0]    ch_xfer;
  logic [NUM_CH-1:0]    own_match;
  logic [NUM_CH-1:0]    match_ev;
  logic [NUM_CH-1:0]    start_hit;
  logic [NUM_CH-1:0]    act_lvl;
  logic [NUM_CH-1:0]    is_cmp;
  logic [NUM_CAP-1:0]   cap_ev;
  logic [STAT_W-1:0]    st_set;
  logic [STAT_W-1:0]    st_clr;

  assign bus_req = wb_req.cyc & wb_req.stb & ~ack_reg;
  assign wr      = bus_req & wb_req.we;

  // unit clock enable: every cycle at double rate, every second cycle otherwise
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_reg <= 1'b0;
    end
    else
    begin
      div_reg <= ~div_reg;
    end
  end
  assign tick = ctrl_reg[CTRL_CLK2X] | div_reg;

  // general timer
  assign gt_step = tick & ctrl_reg[CTRL_GT_RUN];
  assign gt_ovf  = gt_step & (gt_cnt_reg == CNT_MAX);
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gt_cnt_reg <= '0;
    end
    else if (wr && wb_req.adr == OFS_GT_CNT)
    begin
      gt_cnt_reg <= CNT_W'(merge_sel({16'h0, gt_cnt_reg}, wb_req.dat, wb_req.sel));
    end
    else if (gt_ovf)
    begin
      gt_cnt_reg <= gt_reload_reg;
    end
    else if (gt_step)
    begin
      gt_cnt_reg <= gt_cnt_reg + 16'h1;
    end
  end

  // dedicated timer, optionally cascaded, with forced overflow
  assign ct_inc   = ctrl_reg[CTRL_CASCADE] ? gt_ovf : tick;
  assign ct_step  = ct_inc & ctrl_reg[CTRL_CT_RUN];
  assign ct_force = wr && wb_req.adr == OFS_CTRL && wb_req.sel[0] && wb_req.dat[CTRL_CT_FORCE];
  assign ct_ovf   = (ct_step & (ct_cnt_reg == CNT_MAX)) | ct_force;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ct_cnt_reg <= '0;
    end
    else if (wr && wb_req.adr == OFS_CT_CNT)
    begin
      ct_cnt_reg <= CNT_W'(merge_sel({16'h0, ct_cnt_reg}, wb_req.dat, wb_req.sel));
    end
    else if (ct_ovf)
    begin
      ct_cnt_reg <= ct_reload_reg;
    end
    else if (ct_step)
    begin
      ct_cnt_reg <= ct_cnt_reg + 16'h1;
    end
  end

  assign sw_xfer = wr && wb_req.adr == OFS_CTRL && wb_req.sel[0] && wb_req.dat[CTRL_SW_XFER];

  // per channel time base, match and capture events
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      ch_cnt[i]    = tb_sel_reg[i] ? ct_cnt_reg : gt_cnt_reg;
      ch_reload[i] = tb_sel_reg[i] ? ct_reload_reg : gt_reload_reg;
      ch_ovf[i]    = tb_sel_reg[i] ? ct_ovf : gt_ovf;
      is_cmp[i]    = (mode_reg[i] == MODE_CMP0) || (mode_reg[i] == MODE_CMP1);
      ch_xfer[i]   = is_cmp[i] & (sw_xfer | (ctrl_reg[CTRL_AUTO_XF] & ch_ovf[i]));
      cmp_after[i] = ch_xfer[i] ? shadow_reg[i] : value_reg[i];
      own_match[i] = (tb_sel_reg[i] ? ct_step : gt_step) & ~ch_ovf[i]
                     & ((ch_cnt[i] + 16'h1) == value_reg[i]);
      // a compare value equal to the start value holds the output active all period
      start_hit[i] = ch_ovf[i] & (ch_reload[i] == cmp_after[i]);
      act_lvl[i]   = (i <= GROUP_A_HI) ? ctrl_reg[CTRL_LVL_A] : ctrl_reg[CTRL_LVL_B];
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      match_ev[i] = (ctrl_reg[CTRL_CONCUR] && i != 0) ? own_match[0] : own_match[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CAP; i++)
    begin
      logic [1:0] es;
      logic       rise;
      logic       fall;
      es   = cap_cfg_reg[i*CAP_FLD_W +: 2];
      rise = cap_in[i] & ~cap_prev_reg[i];
      fall = ~cap_in[i] & cap_prev_reg[i];
      if (mode_reg[i] != MODE_CAPTURE)
      begin
        cap_ev[i] = 1'b0;
      end
      else if (cap_cfg_reg[i*CAP_FLD_W + CAP_SW_BIT])
      begin
        cap_ev[i] = wr && wb_req.sel[0] && wb_req.adr == ch_ofs(OFS_VALUE0, i);
      end
      else
      begin
        cap_ev[i] = ((es == EDGE_RISE || es == EDGE_BOTH) && rise)
                    || ((es == EDGE_FALL || es == EDGE_BOTH) && fall);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cap_prev_reg <= '0;
    end
    else
    begin
      cap_prev_reg <= cap_in;
    end
  end

  // shadow and active compare / capture values
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!rstn)
      begin
        shadow_reg[i] <= '0;
        value_reg[i]  <= '0;
      end
      else
      begin
        if (wr && wb_req.adr == ch_ofs(OFS_SHADOW0, i))
        begin
          shadow_reg[i] <= CNT_W'(merge_sel({16'h0, shadow_reg[i]}, wb_req.dat, wb_req.sel));
        end
        if (i < NUM_CAP && cap_ev[i])
        begin
          value_reg[i] <= ch_cnt[i];
        end
        else if (ch_xfer[i])
        begin
          value_reg[i] <= shadow_reg[i];
        end
      end
    end
  end

  // compare outputs
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!rstn)
      begin
        out_reg[i] <= 1'b0;
        oe_reg[i]  <= 1'b0;
      end
      else
      begin
        oe_reg[i] <= is_cmp[i];
        case (mode_reg[i])
          MODE_CMP0:
          begin
            if (ch_ovf[i])
            begin
              out_reg[i] <= start_hit[i] ? act_lvl[i] : ~act_lvl[i];
            end
            else if (match_ev[i])
            begin
              out_reg[i] <= act_lvl[i];
            end
            else if (out_reg[i] != act_lvl[i] && out_reg[i] != ~act_lvl[i])
            begin
              out_reg[i] <= ~act_lvl[i];
            end
          end
          MODE_CMP1:
          begin
            if (match_ev[i])
            begin
              out_reg[i] <= m1_level_reg[i];
            end
          end
          default:
          begin
            out_reg[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // status, mask and interrupt
  always_comb
  begin
    st_set = '0;
    st_set[ST_MATCH0 +: NUM_CH] = match_ev & is_cmp;
    st_set[ST_CAP0 +: NUM_CAP]  = cap_ev;
    st_set[ST_GT_OVF]           = gt_ovf;
    st_set[ST_CT_OVF]           = ct_ovf;
    st_clr = '0;
    if (wr && wb_req.adr == OFS_STATUS)
    begin
      st_clr = STAT_W'(merge_sel('0, wb_req.dat, wb_req.sel));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      // a new event beats a clear in the same cycle
      status_reg <= (status_reg & ~st_clr) | st_set;
      irq_reg    <= |(((status_reg & ~st_clr) | st_set) & mask_reg);
    end
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_reg      <= '0;
      gt_reload_reg <= '0;
      ct_reload_reg <= '0;
      tb_sel_reg    <= '0;
      cap_cfg_reg   <= '0;
      m1_level_reg  <= '0;
      mask_reg      <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        mode_reg[i] <= MODE_OFF;
      end
    end
    else if (wr)
    begin
      case (wb_req.adr)
        OFS_CTRL:
        begin
          ctrl_reg <= merge_sel(ctrl_reg, wb_req.dat, wb_req.sel) & CTRL_STORED_MASK;
        end
        OFS_GT_RELOAD:
        begin
          gt_reload_reg <= CNT_W'(merge_sel({16'h0, gt_reload_reg}, wb_req.dat, wb_req.sel));
        end
        OFS_CT_RELOAD:
        begin
          ct_reload_reg <= CNT_W'(merge_sel({16'h0, ct_reload_reg}, wb_req.dat, wb_req.sel));
        end
        OFS_TB_SEL:
        begin
          tb_sel_reg <= NUM_CH'(merge_sel({26'h0, tb_sel_reg}, wb_req.dat, wb_req.sel));
        end
        OFS_CH_MODE:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (wb_req.sel[i/4])
            begin
              // capture exists only on the first four channels
              if (i >= NUM_CAP && wb_req.dat[i*2 +: 2] == 2'(MODE_CAPTURE))
              begin
                mode_reg[i] <= MODE_OFF;
              end
              else
              begin
                mode_reg[i] <= mode_type'(wb_req.dat[i*2 +: 2]);
              end
            end
          end
        end
        OFS_CAP_CFG:
        begin
          cap_cfg_reg <= (NUM_CAP*CAP_FLD_W)'(merge_sel({20'h0, cap_cfg_reg}, wb_req.dat, wb_req.sel));
        end
        OFS_M1_LEVEL:
        begin
          m1_level_reg <= NUM_CH'(merge_sel({26'h0, m1_level_reg}, wb_req.dat, wb_req.sel));
        end
        OFS_MASK:
        begin
          mask_reg <= STAT_W'(merge_sel({20'h0, mask_reg}, wb_req.dat, wb_req.sel));
        end
        default:
        begin
        end
      endcase
    end
  end

  // read mux
  always_comb
  begin
    rdat_next = '0;
    case (wb_req.adr)
      OFS_CTRL:      rdat_next = ctrl_reg;
      OFS_GT_CNT:    rdat_next = {16'h0, gt_cnt_reg};
      OFS_GT_RELOAD: rdat_next = {16'h0, gt_reload_reg};
      OFS_CT_CNT:    rdat_next = {16'h0, ct_cnt_reg};
      OFS_CT_RELOAD: rdat_next = {16'h0, ct_reload_reg};
      OFS_TB_SEL:    rdat_next = {26'h0, tb_sel_reg};
      OFS_CAP_CFG:   rdat_next = {20'h0, cap_cfg_reg};
      OFS_M1_LEVEL:  rdat_next = {26'h0, m1_level_reg};
      OFS_STATUS:    rdat_next = {20'h0, status_reg};
      OFS_MASK:      rdat_next = {20'h0, mask_reg};
      OFS_OUT_STATE: rdat_next = {26'h0, out_reg};
      OFS_CH_MODE:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          rdat_next[i*2 +: 2] = mode_reg[i];
        end
      end
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (wb_req.adr == ch_ofs(OFS_SHADOW0, i))
          begin
            rdat_next = {16'h0, shadow_reg[i]};
          end
          if (wb_req.adr == ch_ofs(OFS_VALUE0, i))
          begin
            rdat_next = {16'h0, value_reg[i]};
          end
        end
      end
    endcase
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end
    else
    begin
      ack_reg  <= bus_req;
      rdat_reg <= bus_req ? rdat_next : '0;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;
  assign cmp_out    = out_reg;
  assign cmp_oe     = oe_reg;
  assign irq        = irq_reg;

endmodule

// file: verif/tcc_checker_properties.sv
// port-level assertions for the timer capture/compare block
`timescale 1ns/1ns
module tcc_checker
(
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire tcc_pkg::wb_req_type         wb_req,
  input wire tcc_pkg::wb_rsp_type         wb_rsp,
  input wire logic [tcc_pkg::NUM_CAP-1:0] cap_in,
  input wire logic [tcc_pkg::NUM_CH-1:0]  cmp_out,
  input wire logic [tcc_pkg::NUM_CH-1:0]  cmp_oe,
  input wire logic                        irq
);
  import tcc_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence wr_ack;
    wb_rsp.ack && wb_req.we;
  endsequence

  ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb))
    else $error("ack without request");
  idle_data_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data not zero outside ack");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> cmp_out == '0 && cmp_oe == '0 && !irq && !wb_rsp.ack)
    else $error("outputs not quiet after reset");
  out_gated_a: assert property ((cmp_out & ~cmp_oe) == '0)
    else $error("compare output high on undriven channel");
  oe_by_write_a: assert property ($changed(cmp_oe) |-> (wb_rsp.ack && wb_req.we) || $past(wb_rsp.ack && wb_req.we))
    else $error("output enable changed without a write");
  irq_clear_a: assert property ($fell(irq) |-> (wb_rsp.ack && wb_req.we) || $past(wb_rsp.ack && wb_req.we))
    else $error("interrupt fell without a write");

  cover property (wr_ack);
  cover property ($rose(irq));
  cover property ($rose(cmp_out[0]));
  cover property (wb_rsp.ack && !wb_req.we);
endmodule

bind timer_capture_compare_block tcc_checker chk_i
(
  .clk     (clk),
  .rstn    (rstn),
  .wb_req  (wb_req),
  .wb_rsp  (wb_rsp),
  .cap_in  (cap_in),
  .cmp_out (cmp_out),
  .cmp_oe  (cmp_oe),
  .irq     (irq)
);

// file: verif/cap_pin_model.sv
// behavioural driver of the capture pins
`timescale 1ns/1ns
module cap_pin_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [1:0] pin_ch,
  input  wire logic [7:0] gap,
  output logic [3:0]      cap_in
);
  logic [7:0] t = 8'h00;
  logic [2:0] left = 3'h0;
  logic [1:0] ch = 2'h0;

  initial cap_in = 4'h0;

  // four toggles of one pin, gap cycles apart, starting low
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      cap_in <= 4'h0;
      left <= 3'h0;
    end
    else if (start)
    begin
      ch <= pin_ch;
      cap_in[pin_ch] <= ~cap_in[pin_ch];
      left <= 3'h3;
      t <= 8'h01;
    end
    else if (left != 3'h0 && t == gap)
    begin
      cap_in[ch] <= ~cap_in[ch];
      left <= left - 3'h1;
      t <= 8'h01;
    end
    else
      t <= t + 8'h01;
  end
endmodule

// file: verif/timer_capture_compare_block_bench.sv
// self-checking bench for the timer capture/compare block
`timescale 1ns/1ns
module timer_capture_compare_block_bench;
  import tcc_pkg::*;

  logic        clk;
  logic        rstn;
  wb_req_type  wb_req;
  wb_rsp_type  wb_rsp;
  logic [3:0]  cap_in;
  logic [5:0]  cmp_out;
  logic [5:0]  cmp_oe;
  logic        irq;
  logic        start;
  logic [1:0]  pin_ch;
  logic [7:0]  gap;
  logic [31:0] v;
  logic [31:0] r0;
  int          failures;
  int          samples_checked;
  int          cyc;

  timer_capture_compare_block dut (.clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
                                   .cap_in(cap_in), .cmp_out(cmp_out), .cmp_oe(cmp_oe), .irq(irq));
  cap_pin_model pins (.clk(clk), .rstn(rstn), .start(start), .pin_ch(pin_ch), .gap(gap), .cap_in(cap_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] duty(logic [15:0] c, logic [15:0] r);
    int p;
    p = 32'h10000 - r;
    if (c == r) return 512;
    if (c < r) return 0;
    return (512 / p) * (32'h10000 - c);
  endfunction

  function automatic int tick(int x, bit fast);
    return fast ? x : x / 2;
  endfunction

  task automatic close_out;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do
    begin
      @(posedge clk);
    end
    while (wb_rsp.ack !== 1'b1);
    v = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_until(int n);
    while (cyc < n) @(posedge clk);
  endtask

  task automatic regs_test;
    rd(OFS_CTRL);
    chk("ctrl", 32'h0, v);
    rd(OFS_STATUS);
    chk("status", 32'h0, v);
    rd(OFS_CH_MODE);
    chk("mode", 32'h0, v);
    chk("oe", 32'h0, cmp_oe);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c);
    chk("unmapped", 32'h0, v);
    wr(OFS_CTRL, 32'h3ff);
    rd(OFS_CTRL);
    chk("ctrl_rw", 32'h3ff & CTRL_STORED_MASK, v);
    $display("test regs done");
  endtask

  task automatic measure(int ch, logic lvl, logic [31:0] e, string nm);
    int hi;
    hi = 0;
    repeat (512) @(posedge clk) if (cmp_out[ch] === lvl) hi++;
    chk(nm, e, hi);
  endtask

  task automatic cmp_test;
    int ch;
    int sel;
    logic lvl;
    logic [15:0] r;
    logic [15:0] c;
    for (int k = 0; k < 3; k++)
    begin
      ch = $urandom % 6;
      sel = $urandom % 2;
      lvl = 1'($urandom % 2);
      r = sel ? 16'hff80 : 16'hff00;
      c = (k == 0) ? r : (k == 1) ? 16'hfe00 : 16'hff80 + 16'($urandom % 128);
      wr(OFS_GT_RELOAD, 32'hff00);
      wr(OFS_GT_CNT, 32'hff00);
      wr(OFS_CT_RELOAD, 32'hff80);
      wr(OFS_CT_CNT, 32'hff80);
      wr(OFS_TB_SEL, 32'(sel) << ch);
      wr(OFS_CH_MODE, 32'h1 << (2 * ch));
      wr(OFS_SHADOW0 + 8'(4 * ch), 32'(c));
      r0 = 32'h7 | (32'(k % 2) << CTRL_AUTO_XF) | (lvl ? 32'h300 : 32'h0);
      wr(OFS_CTRL, r0);
      if (k % 2 == 0) wr(OFS_CTRL, r0 | 32'h20);
      repeat (600) @(posedge clk);
      measure(ch, lvl, duty(c, r), "duty");
      chk("oe", 32'h1, cmp_oe[ch]);
    end
    ch = $urandom % 6;
    wr(OFS_CH_MODE, 32'h2 << (2 * ch));
    wr(OFS_SHADOW0 + 8'(4 * ch), 32'hffc0);
    for (int l = 1; l >= 0; l--)
    begin
      wr(OFS_M1_LEVEL, 32'(l) << ch);
      wr(OFS_CTRL, 32'h27);
      repeat (600) @(posedge clk);
      chk("level", 32'(l), cmp_out[ch]);
    end
    wr(OFS_TB_SEL, 32'h0);
    wr(OFS_CH_MODE, 32'h5);
    wr(OFS_SHADOW0, 32'hffc0);
    wr(OFS_SHADOW0 + 8'h4, 32'hff10);
    wr(OFS_CTRL, 32'h3a7);
    repeat (600) @(posedge clk);
    measure(0, 1'b1, duty(16'hffc0, 16'hff00), "lead");
    measure(1, 1'b1, duty(16'hffc0, 16'hff00), "follow");
    $display("test compare done");
  endtask

  task automatic cap_test;
    int ch;
    int g;
    int s;
    int first;
    int last;
    logic [31:0] base_val;
    for (int m = 0; m < 6; m++)
    begin
      ch = $urandom % 4;
      g = 24 + 2 * ($urandom % 9);
      wr(OFS_CTRL, (m < 3) ? 32'h7 : 32'h3);
      wr(OFS_GT_CNT, 32'h0);
      wr(OFS_CT_RELOAD, 32'h0);
      wr(OFS_CT_CNT, 32'h0);
      wr(OFS_TB_SEL, $urandom % 64);
      wr(OFS_CH_MODE, 32'h3 << (2 * ch));
      wr(OFS_CAP_CFG, 32'(m % 3 + 1) << (3 * ch));
      wr(OFS_STATUS, 32'hfff);
      r0 = 32'h1 << (ST_CAP0 + ch);
      wr(OFS_MASK, r0);
      pin_ch <= 2'(ch);
      gap <= 8'(g);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      s = cyc;
      first = -1;
      last = -1;
      for (int k = 0; k < 4; k++)
      begin
        wait_until(s + 8 + g * k);
        rd(OFS_VALUE0 + 8'(4 * ch));
        // edge kinds: rise on even toggles, fall on odd, both on all
        if (m % 3 == 2 || m % 3 == k % 2) last = k;
        if (last == k && first < 0)
        begin
          first = k;
          base_val = v;
        end
        if (first >= 0) chk("capture", base_val + 32'(tick(g * (last - first), m < 3)), v);
      end
    end
    chk("irq", 32'h1, irq);
    wr(OFS_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq_masked", 32'h0, irq);
    wr(OFS_MASK, r0);
    repeat (3) @(posedge clk);
    chk("irq_unmasked", 32'h1, irq);
    wr(OFS_STATUS, 32'hfff);
    repeat (3) @(posedge clk);
    chk("irq_cleared", 32'h0, irq);
    $display("test capture done");
  endtask

  task automatic soft_test;
    int ch;
    int o;
    int g;
    int s;
    logic [31:0] base_val;
    ch = $urandom % 4;
    o = ch ^ 1;
    g = 40 + $urandom % 40;
    wr(OFS_CH_MODE, (32'h3 << (2 * ch)) | (32'h3 << (2 * o)));
    wr(OFS_CAP_CFG, (32'h5 << (3 * ch)) | (32'h1 << (3 * o)));
    wr(OFS_CTRL, 32'h7);
    s = cyc + 4;
    wait_until(s);
    wr(OFS_VALUE0 + 8'(4 * ch), 32'h0);
    rd(OFS_VALUE0 + 8'(4 * ch));
    r0 = v;
    rd(OFS_VALUE0 + 8'(4 * o));
    base_val = v;
    wait_until(s + g);
    wr(OFS_VALUE0 + 8'(4 * ch), 32'h0);
    wr(OFS_VALUE0 + 8'(4 * o), 32'h0);
    rd(OFS_VALUE0 + 8'(4 * ch));
    chk("soft_capture", r0 + 32'(g), v);
    rd(OFS_VALUE0 + 8'(4 * o));
    chk("pin_mode_kept", base_val, v);
    $display("test soft capture done");
  endtask

  task automatic timer_test;
    wr(OFS_CT_RELOAD, 32'h200);
    wr(OFS_CT_CNT, 32'h1000);
    wr(OFS_STATUS, 32'hfff);
    wr(OFS_CTRL, 32'h6);
    wr(OFS_CTRL, 32'h16);
    rd(OFS_CT_CNT);
    chk("force_reload", 32'h1, v >= 32'h200 && v < 32'h210);
    rd(OFS_STATUS);
    chk("force_ovf", 32'h1, v[ST_CT_OVF]);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_GT_RELOAD, 32'hfff0);
    wr(OFS_GT_CNT, 32'hfff0);
    wr(OFS_CT_CNT, 32'h0);
    wr(OFS_CTRL, 32'hf);
    repeat (320) @(posedge clk);
    rd(OFS_CT_CNT);
    chk("cascade", 32'h1, v >= 19 && v <= 21);
    rd(OFS_GT_CNT);
    chk("gt_range", 32'h1, v >= 32'hfff0 && v <= 32'hffff);
    rd(OFS_STATUS);
    chk("gt_ovf", 32'h1, v[ST_GT_OVF]);
    $display("test timers done");
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out;
  end

  initial
  begin
    wb_req = '0;
    rstn = 1'b0;
    start = 1'b0;
    pin_ch = 2'h0;
    gap = 8'h18;
    failures = 0;
    samples_checked = 0;
    void'($urandom(54));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    regs_test;
    cmp_test;
    cap_test;
    soft_test;
    timer_test;
    close_out;
  end
endmodule
